// ---- include/pressure_serial_pkg.sv ----
// Shared constants and types for the three-wire pressure sensor link.
// Assumes a 20 MHz system clock on both ends of the link.

package pressure_serial_pkg;

  // ****************************************
  // Clocking
  // ****************************************
  localparam int MCLK_HZ = 20_000_000;
  localparam int MCLK_MHZ = 20;
  localparam int MASTER_CLK_HZ = 32768;
  // Half period of the conversion master clock, rounded down
  localparam logic [9:0] MASTER_HALF_CYCLES = 10'(MCLK_HZ / (2 * MASTER_CLK_HZ));
  // Half period of the shift clock made by the host
  localparam int SCLK_HALF_NS = 400;
  localparam logic [7:0] SCLK_HALF_CYCLES = 8'(SCLK_HALF_NS * MCLK_MHZ / 1000);

  // ****************************************
  // Frame layout
  // ****************************************
  localparam logic [2:0] START_PATTERN = 3'h7;
  localparam logic [5:0] SETUP_BITS = 6'h04;
  localparam logic [5:0] STOP_BITS = 6'h03;
  localparam logic [5:0] FRAME_BITS = 6'h0A;
  localparam logic [5:0] RESET_BITS = 6'h15;
  localparam logic [20:0] RESET_PATTERN = 21'h155540;
  localparam logic [5:0] ACK_PULSES = 6'h02;
  localparam logic [5:0] CONV_READ_PULSES = 6'h11;
  localparam logic [5:0] CAL_READ_PULSES = 6'h21;
  localparam logic [5:0] CONV_READ_BITS = 6'h10;
  localparam logic [5:0] CAL_READ_BITS = 6'h20;

  // ****************************************
  // Setup codes
  // ****************************************
  localparam logic [3:0] SETUP_PRESSURE = 4'hA;
  localparam logic [3:0] SETUP_TEMPERATURE = 4'h9;
  localparam logic [3:0] SETUP_CAL13 = 4'h5;
  localparam logic [3:0] SETUP_CAL24 = 4'h6;

  // ****************************************
  // Calibration word positions in 64-bit store
  // ****************************************
  localparam int CAL_WORD_ONE_LSB = 48;
  localparam int CAL_WORD_TWO_LSB = 32;
  localparam int CAL_WORD_THREE_LSB = 16;
  localparam int CAL_WORD_FOUR_LSB = 0;
  localparam logic [63:0] CAL_DATA_DEFAULT = 64'h1111_2222_3333_4444;
  localparam logic [15:0] CONV_TICKS_DEFAULT = 16'h0010;

  // Host commands
  typedef enum logic [2:0] {
    CMD_PRESSURE = 3'h0,
    CMD_TEMPERATURE = 3'h1,
    CMD_CAL13 = 3'h2,
    CMD_CAL24 = 3'h3,
    CMD_RESET = 3'h4
  } cmd_type;

endpackage

// ---- include/sensor_link.sv ----
// Three-wire link plus master clock between host and sensor.
// Assumes the bench instantiates it once and joins both ends.
`timescale 1ns/1ps
`default_nettype none

interface sensor_link;
  logic sclk;
  logic din;
  logic dout;
  logic master_clk;

  modport device(input sclk, input din, input master_clk, output dout);
  modport host(output sclk, output din, output master_clk, input dout);
endinterface

`default_nettype wire

// ---- logic/pin_sync.sv ----
// Two-flop synchroniser with edge detection on the synced level.
// Assumes pin_in is asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Pin
  input wire logic pin_in,
  // Synced view
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Synchroniser chain and edge history
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edges seen only after the second flop
  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule

`default_nettype wire

// ---- logic/sensor_device.sv ----
// Sensor end of the three-wire link: frame decode, conversion, readout.
// Assumes the host drives shift clock, data in and the master clock.
//
// What this block does
// - Capture data in on shift clock rise.
// - Launch data out on shift clock rise.
// - Host samples and changes on falling edge.
// - Host alone makes and paces shift clock.
// - Data out carries results and conversion status.
// - Five instructions: pressure, temperature, two calibrations, reset.
// - Three high start bits open every frame.
// - Three low stop bits close every frame.
// - Decode four-bit setup field.
// - Raise data out in last stop bit of a pressure or temperature frame.
// - Host gives two pulses after acknowledge.
// - Host holds clock low until data out falls.
// - Drop data out when conversion completes.
// - Seventeen pulses shift out 16-bit result.
// - Readout survives clock pauses without loss.
// - Host reads result before next conversion.
// - Reset pattern returns to idle from anywhere.
// - Reset pattern is 21 bits, fully sent.
// - Host sends reset before first conversion.
// - Host supplies continuous 32.768 kHz master clock.
// - Sixty-four calibration bits as four words.
// - Both conversion results are unsigned 16-bit.
`timescale 1ns/1ps
`default_nettype none

module sensor_device
  import pressure_serial_pkg::*;
#(
  parameter logic [63:0] CAL_DATA = CAL_DATA_DEFAULT,
  parameter logic [15:0] CONV_TICKS = CONV_TICKS_DEFAULT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Link
  sensor_link.device link,
  // Analogue front end samples
  input wire logic [15:0] pressure_sample,
  input wire logic [15:0] temperature_sample,
  // Status
  output logic conv_busy,
  output logic resync_pulse,
  output logic frame_error
);

  // ****************************************
  // States
  // ****************************************
  typedef enum logic [5:0] {
    D_IDLE = 6'h01,
    D_SETUP = 6'h02,
    D_STOP = 6'h04,
    D_ACK = 6'h08,
    D_CONV = 6'h10,
    D_READ = 6'h20
  } dev_state_type;

  dev_state_type state_r;
  logic [20:0] hist_r;
  logic [5:0] cnt_r;
  logic [3:0] code_r;
  logic [15:0] tick_r;
  logic [31:0] shift_r;
  logic dout_r;
  logic busy_r;
  logic resync_r;
  logic ferr_r;

  // ****************************************
  // Pin sampling
  // ****************************************
  logic sclk_rise;
  logic din_s;
  logic mst_rise;

  pin_sync sclk_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin_in(link.sclk),
    .level(),
    .rise(sclk_rise),
    .fall()
  );

  pin_sync din_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin_in(link.din),
    .level(din_s),
    .rise(),
    .fall()
  );

  pin_sync mst_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin_in(link.master_clk),
    .level(),
    .rise(mst_rise),
    .fall()
  );

  // ****************************************
  // Decode
  // ****************************************
  logic [20:0] hist_nxt;
  logic rst_hit;
  logic start_hit;
  logic is_conv;
  logic is_cal;
  logic stop_last;
  logic conv_done;
  logic [5:0] read_len;
  logic [31:0] cal_pair;
  logic [15:0] sample_pick;

  // Bit history including the bit arriving now
  assign hist_nxt = {hist_r[19:0], din_s};
  assign rst_hit = sclk_rise && (hist_nxt == RESET_PATTERN);
  assign start_hit = sclk_rise && (hist_nxt[2:0] == START_PATTERN);
  // Setup field meaning
  assign is_conv = (code_r == SETUP_PRESSURE) || (code_r == SETUP_TEMPERATURE);
  assign is_cal = (code_r == SETUP_CAL13) || (code_r == SETUP_CAL24);
  assign stop_last = sclk_rise && (state_r == D_STOP) && (cnt_r == STOP_BITS - 6'h01);
  assign conv_done = (state_r == D_CONV) && mst_rise && (tick_r == CONV_TICKS - 16'h0001);
  assign read_len = is_conv ? CONV_READ_PULSES : CAL_READ_PULSES;
  // Calibration word pair selected by the setup code
  assign cal_pair = (code_r == SETUP_CAL13) ?
    {CAL_DATA[CAL_WORD_ONE_LSB +: 16], CAL_DATA[CAL_WORD_THREE_LSB +: 16]} :
    {CAL_DATA[CAL_WORD_TWO_LSB +: 16], CAL_DATA[CAL_WORD_FOUR_LSB +: 16]};
  assign sample_pick = (code_r == SETUP_PRESSURE) ? pressure_sample : temperature_sample;

  // ****************************************
  // Bit history
  // ****************************************
  // Shifts in every state so the reset pattern is always seen
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hist_r <= 21'h000000;
    end else if (sclk_rise) begin
      hist_r <= hist_nxt;
    end
  end

  // ****************************************
  // Protocol state
  // ****************************************
  // Frame walk; the reset pattern overrides every state
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= D_IDLE;
      cnt_r <= 6'h00;
      code_r <= 4'h0;
    end else if (rst_hit) begin
      state_r <= D_IDLE;
      cnt_r <= 6'h00;
    end else begin
      case (state_r)
        D_IDLE: begin
          cnt_r <= 6'h00;
          if (start_hit) begin
            state_r <= D_SETUP;
          end
        end
        D_SETUP: begin
          if (sclk_rise) begin
            code_r <= {code_r[2:0], din_s};
            if (cnt_r == SETUP_BITS - 6'h01) begin
              state_r <= D_STOP;
              cnt_r <= 6'h00;
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
        end
        D_STOP: begin
          if (sclk_rise) begin
            cnt_r <= cnt_r + 6'h01;
            if (din_s) begin
              state_r <= D_IDLE;
              cnt_r <= 6'h00;
            end else if (stop_last) begin
              cnt_r <= 6'h00;
              if (is_conv) begin
                state_r <= D_ACK;
              end else if (is_cal) begin
                state_r <= D_READ;
              end else begin
                state_r <= D_IDLE;
              end
            end
          end
        end
        D_ACK: begin
          if (sclk_rise) begin
            if (cnt_r == ACK_PULSES - 6'h01) begin
              state_r <= D_CONV;
              cnt_r <= 6'h00;
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
        end
        D_CONV: begin
          if (conv_done) begin
            state_r <= D_READ;
          end
        end
        D_READ: begin
          // Only counted clock edges advance, so pauses lose nothing
          if (sclk_rise) begin
            if (cnt_r == read_len - 6'h01) begin
              state_r <= D_IDLE;
              cnt_r <= 6'h00;
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
        end
        default: begin
          state_r <= D_IDLE;
          cnt_r <= 6'h00;
        end
      endcase
    end
  end

  // ****************************************
  // Conversion timer
  // ****************************************
  // Counts master clock rises while converting
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tick_r <= 16'h0000;
    end else if (state_r != D_CONV || rst_hit) begin
      tick_r <= 16'h0000;
    end else if (mst_rise) begin
      tick_r <= tick_r + 16'h0001;
    end
  end

  // ****************************************
  // Data out and shifter
  // ****************************************
  // Status signalling and result bits share the one output
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      shift_r <= 32'h00000000;
      dout_r <= 1'b0;
    end else if (rst_hit) begin
      dout_r <= 1'b0;
    end else if (stop_last && !din_s) begin
      if (is_conv) begin
        dout_r <= 1'b1;
      end else if (is_cal) begin
        shift_r <= cal_pair;
      end
    end else if (conv_done) begin
      dout_r <= 1'b0;
      shift_r <= {sample_pick, 16'h0000};
    end else if (state_r == D_READ && sclk_rise) begin
      if (cnt_r == read_len - 6'h01) begin
        dout_r <= 1'b0;
      end else begin
        dout_r <= shift_r[31];
        shift_r <= {shift_r[30:0], 1'b0};
      end
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      resync_r <= 1'b0;
      ferr_r <= 1'b0;
    end else begin
      busy_r <= (state_r != D_IDLE);
      resync_r <= rst_hit;
      ferr_r <= !rst_hit && sclk_rise && (state_r == D_STOP) && din_s;
    end
  end

  assign link.dout = dout_r;
  assign conv_busy = busy_r;
  assign resync_pulse = resync_r;
  assign frame_error = ferr_r;

endmodule

`default_nettype wire

// ---- logic/sensor_host.sv ----
// Host end of the three-wire link: makes both clocks and runs commands.
// Assumes one command at a time from the user side.
`timescale 1ns/1ps
`default_nettype none

module sensor_host
  import pressure_serial_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Link
  sensor_link.host link,
  // Command
  input wire logic cmd_valid,
  input wire cmd_type cmd_code,
  output logic cmd_ready,
  // Result
  output logic result_valid,
  output logic [31:0] result_data,
  output logic busy
);

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_SEND = 5'h02,
    H_ACK = 5'h04,
    H_WAIT = 5'h08,
    H_READ = 5'h10
  } host_state_type;

  host_state_type state_r;
  cmd_type cmd_r;
  logic [20:0] frame_r;
  logic [5:0] cnt_r;
  logic [7:0] div_r;
  logic sclk_r;
  logic din_r;
  logic [9:0] mdiv_r;
  logic mst_r;
  logic [31:0] rx_r;
  logic ready_r;
  logic valid_r;
  logic busy_r;
  logic [31:0] data_r;
  logic dout_s;

  // ****************************************
  // Sync and decode
  // ****************************************
  pin_sync dout_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin_in(link.dout),
    .level(dout_s),
    .rise(),
    .fall()
  );

  logic take;
  logic run;
  logic fall_ev;
  logic conv_cmd;
  logic [5:0] send_len;
  logic [5:0] read_len;
  logic [5:0] read_bits;
  logic [3:0] code_bits;

  assign take = cmd_valid && ready_r && (state_r == H_IDLE);
  assign run = (state_r == H_SEND) || (state_r == H_ACK) || (state_r == H_READ);
  assign fall_ev = run && sclk_r && (div_r == SCLK_HALF_CYCLES - 8'h01);
  assign conv_cmd = (cmd_r == CMD_PRESSURE) || (cmd_r == CMD_TEMPERATURE);
  assign send_len = (cmd_r == CMD_RESET) ? RESET_BITS : FRAME_BITS;
  assign read_len = conv_cmd ? CONV_READ_PULSES : CAL_READ_PULSES;
  assign read_bits = conv_cmd ? CONV_READ_BITS : CAL_READ_BITS;
  // Setup code for the command being accepted
  always_comb begin
    case (cmd_code)
      CMD_PRESSURE: code_bits = SETUP_PRESSURE;
      CMD_TEMPERATURE: code_bits = SETUP_TEMPERATURE;
      CMD_CAL13: code_bits = SETUP_CAL13;
      default: code_bits = SETUP_CAL24;
    endcase
  end

  // ****************************************
  // Clock generation
  // ****************************************
  // Shift clock runs only while pulses are wanted
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_r <= 8'h00;
      sclk_r <= 1'b0;
    end else if (!run) begin
      div_r <= 8'h00;
      sclk_r <= 1'b0;
    end else if (div_r == SCLK_HALF_CYCLES - 8'h01) begin
      div_r <= 8'h00;
      sclk_r <= ~sclk_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // Free-running master clock
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mdiv_r <= 10'h000;
      mst_r <= 1'b0;
    end else if (mdiv_r == MASTER_HALF_CYCLES - 10'h001) begin
      mdiv_r <= 10'h000;
      mst_r <= ~mst_r;
    end else begin
      mdiv_r <= mdiv_r + 10'h001;
    end
  end

  // ****************************************
  // Command sequencer
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= H_IDLE;
      cmd_r <= CMD_RESET;
      frame_r <= 21'h000000;
      cnt_r <= 6'h00;
      din_r <= 1'b0;
      rx_r <= 32'h00000000;
    end else begin
      case (state_r)
        H_IDLE: begin
          cnt_r <= 6'h00;
          if (take) begin
            cmd_r <= cmd_code;
            state_r <= H_SEND;
            if (cmd_code == CMD_RESET) begin
              frame_r <= RESET_PATTERN;
              din_r <= RESET_PATTERN[20];
            end else begin
              frame_r <= {START_PATTERN, code_bits, 3'h0, 11'h000};
              din_r <= START_PATTERN[2];
            end
          end
        end
        H_SEND: begin
          if (fall_ev) begin
            frame_r <= {frame_r[19:0], 1'b0};
            din_r <= frame_r[19];
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == send_len - 6'h01) begin
              cnt_r <= 6'h00;
              din_r <= 1'b0;
              if (cmd_r == CMD_RESET) begin
                state_r <= H_IDLE;
              end else if (conv_cmd) begin
                state_r <= H_ACK;
              end else begin
                state_r <= H_READ;
              end
            end
          end
        end
        H_ACK: begin
          if (fall_ev) begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == ACK_PULSES - 6'h01) begin
              state_r <= H_WAIT;
              cnt_r <= 6'h00;
            end
          end
        end
        H_WAIT: begin
          if (!dout_s) begin
            state_r <= H_READ;
          end
        end
        H_READ: begin
          if (fall_ev) begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r < read_bits) begin
              rx_r <= {rx_r[30:0], dout_s};
            end
            if (cnt_r == read_len - 6'h01) begin
              state_r <= H_IDLE;
              cnt_r <= 6'h00;
            end
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // User-side handshake
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ready_r <= 1'b0;
      valid_r <= 1'b0;
      busy_r <= 1'b0;
      data_r <= 32'h00000000;
    end else begin
      ready_r <= (state_r == H_IDLE) && !take;
      busy_r <= (state_r != H_IDLE) || take;
      valid_r <= 1'b0;
      if (state_r == H_READ && fall_ev && cnt_r == read_len - 6'h01) begin
        valid_r <= 1'b1;
        data_r <= conv_cmd ? {16'h0000, rx_r[15:0]} : rx_r;
      end
    end
  end

  assign link.sclk = sclk_r;
  assign link.din = din_r;
  assign link.master_clk = mst_r;
  assign cmd_ready = ready_r;
  assign result_valid = valid_r;
  assign result_data = data_r;
  assign busy = busy_r;

endmodule

`default_nettype wire

// ---- tb/sensor_link_checker.sv ----
// Checker of the link wires between the host and sensor ends.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
`default_nettype none

module sensor_link_checker
  import pressure_serial_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Link wires
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic master_clk
);
  // ****
  // Helper logic
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [9:0] half_cnt_r;
  logic half_seen_r;

  // Cycles since the master clock last changed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      half_cnt_r <= 10'h000;
      half_seen_r <= 1'b0;
    end else if ($changed(master_clk)) begin
      half_cnt_r <= 10'h000;
      half_seen_r <= 1'b1;
    end else begin
      half_cnt_r <= half_cnt_r + 10'h001;
    end
  end

  // ****
  // Properties
  // ****
  property p_din_hold;
    $rose(sclk) |-> $stable(din) [*8];
  endproperty
  a_din_hold: assert property (p_din_hold) else $error("din moved while sclk high");
  property p_sclk_high;
    $rose(sclk) |-> sclk [*8] ##1 !sclk;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("sclk high phase wrong");
  property p_sclk_low;
    $fell(sclk) |-> !sclk [*8];
  endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("sclk low phase short");
  property p_dout_quiet;
    $rose(sclk) |=> $stable(dout) [*2];
  endproperty
  a_dout_quiet: assert property (p_dout_quiet) else $error("dout moved too soon");
  property p_dout_window;
    $changed(dout) && sclk |-> !$past(sclk, 5);
  endproperty
  a_dout_window: assert property (p_dout_window) else $error("dout moved late");
  property p_dout_rise;
    $rose(dout) |-> sclk;
  endproperty
  a_dout_rise: assert property (p_dout_rise) else $error("dout rose with sclk low");
  property p_master_half;
    $changed(master_clk) && half_seen_r |-> half_cnt_r == MASTER_HALF_CYCLES - 10'h001;
  endproperty
  a_master_half: assert property (p_master_half) else $error("master clock half period");
  property p_eoc_read;
    $fell(dout) && !sclk |-> ##[1:40] $rose(sclk);
  endproperty
  a_eoc_read: assert property (p_eoc_read) else $error("no readout after end of conversion");
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
// Bench joining host and sensor ends over one link.
// Assumes the package and both design ends are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import pressure_serial_pkg::*;
;
  localparam logic [63:0] CAL = 64'hA5C3_0F0F_8001_7FFE;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_type cmd_code = CMD_RESET;
  logic [15:0] pressure_sample = 16'h0000;
  logic [15:0] temperature_sample = 16'h0000;
  logic cmd_ready, result_valid, busy, conv_busy, resync_pulse, frame_error;
  logic [31:0] result_data;
  int error_cnt = 0;
  int checked = 0;
  int rise_cnt = 0;
  logic [20:0] frame_r = 21'h000000;
  logic ack_pre_r, ack_r;
  logic seen_valid_r, seen_resync_r, seen_busy_r, seen_ferr_r;

  sensor_link link();
  sensor_device #(.CAL_DATA(CAL), .CONV_TICKS(16'h0002)) i_sensor_device (.mclk(mclk), .nrst(nrst),
    .link(link), .pressure_sample(pressure_sample), .temperature_sample(temperature_sample),
    .conv_busy(conv_busy), .resync_pulse(resync_pulse), .frame_error(frame_error));
  sensor_host i_sensor_host (.mclk(mclk), .nrst(nrst), .link(link), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready), .result_valid(result_valid),
    .result_data(result_data), .busy(busy));
  sensor_link_checker i_sensor_link_checker (.mclk(mclk), .nrst(nrst), .sclk(link.sclk),
    .din(link.din), .dout(link.dout), .master_clk(link.master_clk));

  // 20 MHz system clock
  always #25 mclk = ~mclk;

  // Wire monitor: frame bits and acknowledge level at shift clock rises
  always @(posedge link.sclk) begin
    if (rise_cnt < 21) frame_r <= {frame_r[19:0], link.din};
    if (rise_cnt == 9) ack_pre_r <= link.dout;
    if (rise_cnt == 10) ack_r <= link.dout;
    rise_cnt <= rise_cnt + 1;
  end

  // Sticky views of the one-cycle flags and the conversion busy level
  always @(posedge mclk) begin
    if (result_valid === 1'b1) seen_valid_r <= 1'b1;
    if (resync_pulse === 1'b1) seen_resync_r <= 1'b1;
    if (conv_busy === 1'b1) seen_busy_r <= 1'b1;
    if (frame_error === 1'b1) seen_ferr_r <= 1'b1;
  end

  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One command through the host, then pulse count and frame checks
  task automatic run_cmd(input cmd_type code, input int rises);
    int n;
    n = 0;
    @(negedge mclk);
    rise_cnt = 0;
    {seen_valid_r, seen_resync_r, seen_busy_r, seen_ferr_r} = 4'h0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    cmd_code = code;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    check({31'h0, busy}, 32'h1, "host busy after take");
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    // A hung command runs the limit out and counts as a mismatch here
    check({31'h0, cmd_ready}, 32'h1, "host back to ready");
    repeat (40) @(negedge mclk);
    check(32'(rise_cnt), 32'(rises), "sclk pulse count");
    check({31'h0, busy}, 32'h0, "host idle");
    check({31'h0, seen_ferr_r}, 32'h0, "frame error");
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    run_cmd(CMD_RESET, 21);
    check({11'h0, frame_r}, {11'h0, RESET_PATTERN}, "reset pattern");
    check({31'h0, seen_resync_r}, 32'h1, "resync");
    check({31'h0, seen_valid_r}, 32'h0, "result on reset");
    $display("test reset done");
  endtask

  task automatic t_cal(input cmd_type code, input logic [3:0] setup, input logic [31:0] exp);
    run_cmd(code, 43);
    check({22'h0, frame_r[20:11]}, {22'h0, 3'h7, setup, 3'h0}, "cal frame");
    check(result_data, exp, "cal words");
    check({31'h0, seen_valid_r}, 32'h1, "cal result");
    $display("test calibration done");
  endtask

  task automatic t_conv(input cmd_type code, input logic [3:0] setup, input logic [15:0] smp);
    pressure_sample = (code == CMD_PRESSURE) ? smp : ~smp;
    temperature_sample = (code == CMD_PRESSURE) ? ~smp : smp;
    run_cmd(code, 29);
    check({22'h0, frame_r[20:11]}, {22'h0, 3'h7, setup, 3'h0}, "conv frame");
    check({30'h0, ack_pre_r, ack_r}, 32'h1, "acknowledge");
    check({31'h0, seen_busy_r}, 32'h1, "conversion busy");
    check(result_data, {16'h0, smp}, "conv result");
    $display("test conversion done");
  endtask

  // Main sequence
  initial begin
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    t_reset();
    t_cal(CMD_CAL13, SETUP_CAL13, {CAL[CAL_WORD_ONE_LSB +: 16], CAL[CAL_WORD_THREE_LSB +: 16]});
    t_cal(CMD_CAL24, SETUP_CAL24, {CAL[CAL_WORD_TWO_LSB +: 16], CAL[CAL_WORD_FOUR_LSB +: 16]});
    t_conv(CMD_PRESSURE, SETUP_PRESSURE, 16'hFFFF);
    t_conv(CMD_TEMPERATURE, SETUP_TEMPERATURE, 16'h8001);
    t_conv(CMD_PRESSURE, SETUP_PRESSURE, 16'h0001);
    t_reset();
    finish_test();
  end

  // Watchdog well beyond the expected run of about 5900 cycles
  initial begin
    #2_000_000;
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    finish_test();
  end
endmodule

`default_nettype wire
